// ===== hdl/clock_calendar_pkg.sv
// package: register map, field positions and bus codes of the rtc control
package clock_calendar_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_TIME    = 8'h04;
    localparam int         ADDR_W       = 8;

    // ==========================================================
    // control register fields
    localparam int CAL_W      = 10;
    localparam int CAL_LSB    = 16;
    localparam int CAL_MSB    = 25;
    localparam int BIT_ENABLE = 15;
    localparam int BIT_IDLE   = 13;
    localparam int BIT_SEL    = 7;
    localparam int BIT_RUN    = 6;
    localparam int BIT_UNLOCK = 3;
    localparam int BIT_HALF   = 1;
    localparam int BIT_OE     = 0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

    // ==========================================================
    // time register seconds field
    localparam int SEC_LSB = 8;
    localparam int SEC_MSB = 14;
    localparam int SEC_W   = 7;

    // ==========================================================
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/clock_calendar_cal_if.sv
// interface: link between control logic and drift calibration unit
`timescale 1ns/1ps
interface clock_calendar_cal_if;
    logic                       enable;
    logic [clock_calendar_pkg::CAL_W-1:0] cal_value;
    logic                       tick_in;
    logic                       minute;
    logic                       tick_out;

    modport ctrl (output enable, output cal_value, output tick_in,
                  output minute, input tick_out);
    modport cal  (input enable, input cal_value, input tick_in,
                  input minute, output tick_out);
endinterface

// ===== hdl/clock_calendar_cal.sv
// module: drift calibration, adds or swallows timebase pulses per minute
`timescale 1ns/1ps
module clock_calendar_cal (
    input  wire logic CLK,
    input  wire logic RST_N,
    clock_calendar_cal_if.cal   cal
);
    localparam int CW = clock_calendar_pkg::CAL_W;

    logic [CW-1:0] pending_reg;
    logic          add_mode_reg;
    logic          tick_d_reg;
    logic          tick_out_reg;

    assign cal.tick_out = tick_out_reg;

    // ==========================================================
    // correction budget, reloaded at each minute boundary
    always_ff @(posedge CLK) begin
        if (!RST_N || !cal.enable) begin
            pending_reg  <= '0;
            add_mode_reg <= 1'b0;
        end else if (cal.minute) begin
            // positive code adds N, negative code removes -N (to 512)
            add_mode_reg <= ~cal.cal_value[CW-1];             // [RULE_02]
            pending_reg  <= cal.cal_value[CW-1] ?
                            (~cal.cal_value + CW'(1)) :        // [RULE_03]
                            cal.cal_value;                     // [RULE_02]
        end else if (pending_reg != '0) begin
            if (add_mode_reg && tick_d_reg && !cal.tick_in)
                pending_reg <= pending_reg - CW'(1);
            else if (!add_mode_reg && cal.tick_in)
                pending_reg <= pending_reg - CW'(1);
        end
    end

    // ==========================================================
    // extra pulse goes in the cycle after a real one, so never merges
    always_ff @(posedge CLK) begin
        if (!RST_N || !cal.enable) begin
            tick_d_reg   <= 1'b0;
            tick_out_reg <= 1'b0;
        end else begin
            tick_d_reg <= cal.tick_in;
            if (pending_reg == '0 || cal.minute)
                tick_out_reg <= cal.tick_in;                   // [RULE_02]
            else if (add_mode_reg)
                tick_out_reg <= cal.tick_in |
                                (tick_d_reg & ~cal.tick_in);   // [RULE_02]
            else
                tick_out_reg <= 1'b0;                          // [RULE_03]
        end
    end
endmodule

// ===== hdl/clock_calendar_ctrl.sv
// module: rtc control and calibration register block with axi4-lite slave
`timescale 1ns/1ps
// Functional notes
// RULE_01 - drift calibration is a signed 10-bit value in bits 25:16
// RULE_02 - positive value N adds N timebase pulses per minute; zero none
// RULE_03 - negative value removes its magnitude per minute, up to 512
// RULE_04 - bit 15 set switches the module on; clear switches it off
// RULE_05 - enable bit only changes while the write unlock bit is one
// RULE_06 - idle-stop bit 13 gates the bus clock off on idle entry
// RULE_07 - bit 7 picks seconds clock (1) or alarm pulse (0) for the pin
// RULE_08 - the pin is driven only while output enable bit 0 is one
// RULE_09 - read-only bit 6 shows whether the timebase clock runs
// RULE_10 - write unlock sets only while the system unlock sequence is open
// RULE_11 - half-second flag is read-only, cleared by seconds field writes
// RULE_12 - control register resets only on power-on reset
// RULE_13 - bits 31:26, 14 and 12:8 ignore writes and read as zero
// RULE_14 - software avoids access the cycle after clearing enable
// RULE_15 - locked enable keeps its value; other fields still update
module clock_calendar_ctrl (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        SYS_RST_N,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic [2:0]  S_AXI_AWPROT,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic [2:0]  S_AXI_ARPROT,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        UNLOCK_ACTIVE,
    input  wire logic        IDLE_MODE,
    input  wire logic        OSC_RUNNING,
    input  wire logic        HALF_SEC_TICK,
    input  wire logic        TIMEBASE_TICK,
    input  wire logic        MINUTE_TICK,
    input  wire logic        SECONDS_CLK,
    input  wire logic        ALARM_PULSE,
    output logic             MODULE_ENABLE,
    output logic             BUS_CLK_GATE,
    output logic             TIMEBASE_RUNNING,
    output logic             CAL_TICK,
    output logic             PIN_OUT,
    output logic             PIN_OE_N,
    output logic [6:0]       SECONDS_VALUE,
    output logic             SECONDS_LOAD
);
    // ==========================================================
    // storage
    logic [clock_calendar_pkg::CAL_W-1:0] cal_reg;
    logic                       enable_reg;
    logic                       idle_stop_reg;
    logic                       pin_output_select_reg;
    logic                       write_unlock_reg;
    logic                       pin_output_enable_reg;
    logic                       half_second_flag_reg;
    logic                       timebase_running_reg;
    logic                       gate_reg;
    logic                       pin_reg;
    logic                       pin_oe_n_reg;
    logic [clock_calendar_pkg::SEC_W-1:0] seconds_reg;
    logic                       sec_load_reg;

    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;

    logic        bus_rst;
    logic        wr_fire;
    logic        wr_ctrl;
    logic        wr_time;
    logic [31:0] ctrl_merged;
    logic [31:0] time_merged;
    logic [31:0] ctrl_view;

    clock_calendar_cal_if cal_bus ();

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction

    // ==========================================================
    // register read view, unimplemented positions forced to zero
    always_comb begin
        ctrl_view = '0;                                        // [RULE_13]
        ctrl_view[clock_calendar_pkg::CAL_MSB:clock_calendar_pkg::CAL_LSB] = cal_reg;
        ctrl_view[clock_calendar_pkg::BIT_ENABLE] = enable_reg;
        ctrl_view[clock_calendar_pkg::BIT_IDLE]   = idle_stop_reg;
        ctrl_view[clock_calendar_pkg::BIT_SEL]    = pin_output_select_reg;
        ctrl_view[clock_calendar_pkg::BIT_RUN]    = timebase_running_reg; // [RULE_09]
        ctrl_view[clock_calendar_pkg::BIT_UNLOCK] = write_unlock_reg;
        ctrl_view[clock_calendar_pkg::BIT_HALF]   = half_second_flag_reg;
        ctrl_view[clock_calendar_pkg::BIT_OE]     = pin_output_enable_reg;
    end

    assign bus_rst     = !RST_N || !SYS_RST_N;
    assign wr_fire     = !awready_reg && !wready_reg && !bvalid_reg;
    assign wr_ctrl     = wr_fire && awaddr_reg == clock_calendar_pkg::ADDR_CONTROL;
    assign wr_time     = wr_fire && awaddr_reg == clock_calendar_pkg::ADDR_TIME;
    assign ctrl_merged = merge_bytes(ctrl_view, wdata_reg, wstrb_reg);
    assign time_merged = merge_bytes({17'h0_0000, seconds_reg, 8'h00},
                                     wdata_reg, wstrb_reg);

    // ==========================================================
    // write channels: address and data held until both arrive
    always_ff @(posedge CLK) begin
        if (bus_rst) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
        end else if (bvalid_reg && S_AXI_BREADY) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
        end else begin
            if (awready_reg && S_AXI_AWVALID) begin
                awready_reg <= 1'b0;
                awaddr_reg  <= {S_AXI_AWADDR[7:2], 2'b00};
            end
            if (wready_reg && S_AXI_WVALID) begin
                wready_reg <= 1'b0;
                wdata_reg  <= S_AXI_WDATA;
                wstrb_reg  <= S_AXI_WSTRB;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (bus_rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= clock_calendar_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_ctrl || wr_time) ? clock_calendar_pkg::RESP_OKAY :
                                                 clock_calendar_pkg::RESP_SLVERR;
        end else if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // read channel, one cycle from address to data
    always_ff @(posedge CLK) begin
        if (bus_rst) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= clock_calendar_pkg::RESP_OKAY;
            rdata_reg   <= '0;
        end else if (arready_reg && S_AXI_ARVALID) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= clock_calendar_pkg::RESP_OKAY;
            case ({S_AXI_ARADDR[7:2], 2'b00})
                clock_calendar_pkg::ADDR_CONTROL: begin
                    rdata_reg <= ctrl_view;
                end
                clock_calendar_pkg::ADDR_TIME: begin
                    rdata_reg <= {17'h0_0000, seconds_reg, 8'h00};
                end
                default: begin
                    rdata_reg <= '0;
                    rresp_reg <= clock_calendar_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // ==========================================================
    // control fields: only power-on reset clears them
    always_ff @(posedge CLK) begin
        if (!RST_N) begin                                      // [RULE_12]
            cal_reg               <= clock_calendar_pkg::CONTROL_RESET[
                                         clock_calendar_pkg::CAL_MSB:clock_calendar_pkg::CAL_LSB];
            idle_stop_reg         <= 1'b0;
            pin_output_select_reg <= 1'b0;
            pin_output_enable_reg <= 1'b0;
        end else if (wr_ctrl) begin
            // unimplemented write bits are simply not stored
            cal_reg <= ctrl_merged[clock_calendar_pkg::CAL_MSB:
                                   clock_calendar_pkg::CAL_LSB];         // [RULE_01]
            idle_stop_reg <= ctrl_merged[clock_calendar_pkg::BIT_IDLE];  // [RULE_15]
            pin_output_select_reg <= ctrl_merged[clock_calendar_pkg::BIT_SEL];
            pin_output_enable_reg <= ctrl_merged[clock_calendar_pkg::BIT_OE];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            enable_reg <= clock_calendar_pkg::CONTROL_RESET[clock_calendar_pkg::BIT_ENABLE];
        end else if (wr_ctrl && write_unlock_reg) begin        // [RULE_05]
            enable_reg <= ctrl_merged[clock_calendar_pkg::BIT_ENABLE];   // [RULE_04]
        end                                                    // [RULE_15]
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            write_unlock_reg <= 1'b0;
        end else if (wr_ctrl) begin
            // clearing is always allowed, setting needs the open sequence
            if (!ctrl_merged[clock_calendar_pkg::BIT_UNLOCK])
                write_unlock_reg <= 1'b0;
            else if (UNLOCK_ACTIVE)
                write_unlock_reg <= 1'b1;                      // [RULE_10]
        end
    end

    // ==========================================================
    // seconds field and half-second flag
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            seconds_reg  <= '0;
            sec_load_reg <= 1'b0;
        end else begin
            sec_load_reg <= wr_time && wstrb_reg[1];
            if (wr_time)
                seconds_reg <= time_merged[clock_calendar_pkg::SEC_MSB:
                                           clock_calendar_pkg::SEC_LSB];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N)
            half_second_flag_reg <= 1'b0;
        else if (wr_time && wstrb_reg[1])
            half_second_flag_reg <= 1'b0;                      // [RULE_11]
        else if (HALF_SEC_TICK && enable_reg)
            half_second_flag_reg <= ~half_second_flag_reg;
    end

    // ==========================================================
    // status, idle gating and output pin
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            timebase_running_reg <= 1'b0;
            gate_reg             <= 1'b0;
        end else begin
            timebase_running_reg <= enable_reg && OSC_RUNNING; // [RULE_09]
            gate_reg             <= IDLE_MODE && idle_stop_reg; // [RULE_06]
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pin_reg      <= 1'b0;
            pin_oe_n_reg <= 1'b1;
        end else begin
            pin_oe_n_reg <= !(enable_reg && pin_output_enable_reg); // [RULE_08]
            pin_reg <= pin_output_select_reg ? SECONDS_CLK :
                                               ALARM_PULSE;    // [RULE_07]
        end
    end

    // ==========================================================
    // calibration unit
    assign cal_bus.enable    = enable_reg && !gate_reg;
    assign cal_bus.cal_value = cal_reg;
    assign cal_bus.tick_in   = TIMEBASE_TICK;
    assign cal_bus.minute    = MINUTE_TICK;

    clock_calendar_cal u_cal (
        .CLK   (CLK),
        .RST_N (RST_N),
        .cal   (cal_bus.cal)
    );

    // ==========================================================
    // ports
    assign S_AXI_AWREADY    = awready_reg;
    assign S_AXI_WREADY     = wready_reg;
    assign S_AXI_BVALID     = bvalid_reg;
    assign S_AXI_BRESP      = bresp_reg;
    assign S_AXI_ARREADY    = arready_reg;
    assign S_AXI_RVALID     = rvalid_reg;
    assign S_AXI_RRESP      = rresp_reg;
    assign S_AXI_RDATA      = rdata_reg;
    assign MODULE_ENABLE    = enable_reg;
    assign BUS_CLK_GATE     = gate_reg;
    assign TIMEBASE_RUNNING = timebase_running_reg;
    assign CAL_TICK         = cal_bus.tick_out;
    assign PIN_OUT          = pin_reg;
    assign PIN_OE_N         = pin_oe_n_reg;
    assign SECONDS_VALUE    = seconds_reg;
    assign SECONDS_LOAD     = sec_load_reg;
endmodule

// ===== verif/clock_calendar_ctrl_properties.sv
// checker: bus handshake and control output properties of clock_calendar_ctrl
`timescale 1ns/1ps
module clock_calendar_ctrl_props (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic        IDLE_MODE,
    input wire logic        OSC_RUNNING,
    input wire logic        MODULE_ENABLE,
    input wire logic        BUS_CLK_GATE,
    input wire logic        TIMEBASE_RUNNING,
    input wire logic        CAL_TICK,
    input wire logic        PIN_OE_N
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // ==========================================================
    // assertions
    chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY
        && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
        else $error("write response not on time");
    chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID) else $error("read response not on time");
    chk_one_write: assert property (S_AXI_BVALID && S_AXI_BREADY
        |=> !S_AXI_BVALID) else $error("write response repeated");
    chk_one_read: assert property (S_AXI_RVALID && S_AXI_RREADY
        |=> !S_AXI_RVALID) else $error("read response repeated");
    chk_run_status: assert property (
        TIMEBASE_RUNNING == $past(MODULE_ENABLE && OSC_RUNNING))
        else $error("running status wrong");
    chk_idle_gate: assert property (
        BUS_CLK_GATE |-> $past(IDLE_MODE))
        else $error("bus clock gated outside idle");
    chk_pin_enable: assert property (
        !PIN_OE_N |-> $past(MODULE_ENABLE))
        else $error("pin driven while module off");
    chk_enable_lock: assert property (
        $changed(MODULE_ENABLE) |-> $rose(S_AXI_BVALID))
        else $error("enable changed without a write");
    chk_cal_quiet: assert property (
        !MODULE_ENABLE && !$past(MODULE_ENABLE) |-> !CAL_TICK)
        else $error("calibrated tick while off");
    cov_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
    cov_gate: cover property (BUS_CLK_GATE);
    cov_enable: cover property ($rose(MODULE_ENABLE));
endmodule

bind clock_calendar_ctrl clock_calendar_ctrl_props chk_u (.CLK(CLK), .RST_N(RST_N),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .IDLE_MODE(IDLE_MODE), .OSC_RUNNING(OSC_RUNNING),
    .MODULE_ENABLE(MODULE_ENABLE), .BUS_CLK_GATE(BUS_CLK_GATE),
    .TIMEBASE_RUNNING(TIMEBASE_RUNNING), .CAL_TICK(CAL_TICK),
    .PIN_OE_N(PIN_OE_N));

// ===== verif/clock_calendar_ctrl_tb_top.sv
// testbench: register access and control output tests for clock_calendar_ctrl
`timescale 1ns/1ps
module clock_calendar_ctrl_tb_top;
    logic        clk, rst_n, sys_rst_n;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic        unlock, idle, osc, half, tick, minute, secclk, alarm;
    logic        mod_en, gate, running, cal_tick, pin_out, pin_oe_n;
    logic        sec_load;
    logic [6:0]  sec_val;
    int          n_errors, checks_done;

    clock_calendar_ctrl dut_u (.CLK(clk), .RST_N(rst_n), .SYS_RST_N(sys_rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .UNLOCK_ACTIVE(unlock), .IDLE_MODE(idle),
        .OSC_RUNNING(osc), .HALF_SEC_TICK(half), .TIMEBASE_TICK(tick),
        .MINUTE_TICK(minute), .SECONDS_CLK(secclk), .ALARM_PULSE(alarm),
        .MODULE_ENABLE(mod_en), .BUS_CLK_GATE(gate),
        .TIMEBASE_RUNNING(running), .CAL_TICK(cal_tick),
        .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .SECONDS_VALUE(sec_val),
        .SECONDS_LOAD(sec_load));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a new request always waits one edge, so no signal is set twice
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rs = bresp;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rs = rresp;
        chk(rdata, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // raw ticks every fourth cycle leave room for inserted pulses
    task automatic cal_run(input logic [9:0] c, input logic [31:0] exp);
        logic [31:0] cnt;
        wr(clock_calendar_pkg::ADDR_CONTROL, {6'h00, c, 16'h8008}, 4'hf);
        @(posedge clk);
        minute <= 1'b1;
        @(posedge clk);
        minute <= 1'b0;
        cnt = 0;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            tick <= (i % 4 == 0) && (i < 40);
            #1;
            cnt = cnt + cal_tick;
        end
        chk(cnt, exp);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end

    // ==========================================================
    // tests
    initial begin
        n_errors = 0;
        checks_done = 0;
        {rst_n, awaddr, araddr, awvalid, wvalid, bready} = '0;
        {arvalid, rready, wdata, unlock, idle, half, tick, minute} = '0;
        {alarm, sys_rst_n, osc, secclk, wstrb} = {3'h7, 1'b1, 4'hf};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(clock_calendar_pkg::ADDR_CONTROL, 32'h0000_0000);
        $display("test reset done");
        wr(clock_calendar_pkg::ADDR_CONTROL, 32'hffff_ffff, 4'hf);
        rd_chk(clock_calendar_pkg::ADDR_CONTROL, 32'h03ff_2081);
        chk(mod_en, 1'b0);
        @(posedge clk);
        unlock <= 1'b1;
        wr(clock_calendar_pkg::ADDR_CONTROL, 32'h0000_0008, 4'hf);
        wr(clock_calendar_pkg::ADDR_CONTROL, 32'h0000_8089, 4'hf);
        rd_chk(clock_calendar_pkg::ADDR_CONTROL, 32'h0000_80c9);
        chk(running, 1'b1);
        $display("test lock done");
        settle(2);
        chk(pin_out, 1'b1);
        chk(pin_oe_n, 1'b0);
        @(posedge clk);
        secclk <= 1'b0;
        settle(2);
        chk(pin_out, 1'b0);
        wr(clock_calendar_pkg::ADDR_CONTROL, 32'h0000_8008, 4'hf);
        settle(2);
        chk(pin_out, 1'b1);
        chk(pin_oe_n, 1'b1);
        $display("test pin done");
        for (int k = 1; k >= 0; k--) begin
            wr(clock_calendar_pkg::ADDR_CONTROL, k ? 32'h0000_a008 : 32'h8008, 4'hf);
            idle <= 1'b1;
            settle(2);
            chk(gate, k[0]);
            @(posedge clk);
            idle <= 1'b0;
            settle(2);
            chk(gate, 1'b0);
        end
        $display("test idle done");
        @(posedge clk);
        half <= 1'b1;
        @(posedge clk);
        half <= 1'b0;
        rd_chk(clock_calendar_pkg::ADDR_CONTROL, 32'h0000_804a);
        wr(clock_calendar_pkg::ADDR_TIME, 32'h0000_2a00, 4'h2);
        chk(sec_load, 1'b1);
        rd_chk(clock_calendar_pkg::ADDR_CONTROL, 32'h0000_8048);
        rd_chk(clock_calendar_pkg::ADDR_TIME, 32'h0000_2a00);
        chk(sec_val, 7'h2a);
        $display("test half second done");
        @(posedge clk);
        sys_rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        sys_rst_n <= 1'b1;
        rd_chk(clock_calendar_pkg::ADDR_CONTROL, 32'h0000_8048);
        wr(8'h10, 32'hffff_ffff, 4'hf);
        chk(rs, clock_calendar_pkg::RESP_SLVERR);
        rd_chk(8'h10, 32'h0000_0000);
        chk(rs, clock_calendar_pkg::RESP_SLVERR);
        $display("test soft reset done");
        cal_run(10'h003, 32'd13);
        cal_run(10'h000, 32'd10);
        cal_run(10'h1ff, 32'd20);
        cal_run(10'h3fe, 32'd8);
        cal_run(10'h3ff, 32'd9);
        cal_run(10'h200, 32'd0);
        rd_chk(clock_calendar_pkg::ADDR_CONTROL, 32'h0200_8048);
        wr(clock_calendar_pkg::ADDR_CONTROL, 32'h0200_0008, 4'hf);
        @(posedge clk);
        chk(mod_en, 1'b0);
        chk(running, 1'b0);
        $display("test calibration done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(clock_calendar_pkg::ADDR_CONTROL, 32'h0000_0000);
        $display("test power on done");
        results();
    end
endmodule
